//--- dsps_status_scale.sv
// Purpose : drive status words and position scaling parameters
// Assumes : parameter port single-cycle strobes, inputs synchronous
// Notes   : i_to_int_req and i_to_usr_req arriving while busy are dropped; an enable edge waits
`timescale 1ns/1ps
`include "dsps_cfg.svh"
module dsps_status_scale
  import dsps_pkg::*;
(
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_srst,
  // parameter access port
  input  wire logic               i_par_wr,
  input  wire logic               i_par_rd,
  input  wire logic        [15:0] i_par_addr,
  input  wire logic        [31:0] i_par_wdata,
  output logic             [31:0] o_par_rdata,
  output logic                    o_par_ack,
  output logic                    o_par_err,
  // monitoring sources
  input  wire logic        [15:0] i_warn_active,
  input  wire logic               i_fault_clear_command,
  input  wire logic        [3:0]  i_err_class_active,
  input  wire logic               i_stop_fault_valid,
  input  wire logic        [15:0] i_stop_fault_number,
  // motion state
  input  wire logic signed [31:0] i_motor_speed_rpm,
  input  wire logic               i_pg_idle,
  input  wire logic               i_pg_accel,
  input  wire logic               i_pg_const,
  input  wire logic               i_power_enabled,
  // position conversion
  input  wire logic signed [31:0] i_user_pos,
  input  wire logic               i_to_int_req,
  input  wire logic signed [31:0] i_int_pos,
  input  wire logic               i_to_usr_req,
  input  wire logic signed [31:0] i_pos_deviation,
  // outputs
  output logic             [15:0] o_saved_warning_word,
  output logic             [15:0] o_drive_action_word,
  output logic             [15:0] o_tracking_error_class,
  output logic signed      [31:0] o_int_pos,
  output logic signed      [31:0] o_user_pos,
  output logic                    o_conv_done,
  output logic                    o_range_error,
  output logic signed      [31:0] o_ctrl_deviation
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [15:0] tracking_error_class;
  logic [31:0] scale_numerator_reg;
  logic [31:0] scale_denominator_reg;
  logic [31:0] active_num;
  logic [31:0] active_den;
  logic [15:0] last_stop_error_number;
  logic [15:0] drive_action_word;
  logic        pwr_q;
  logic        enable_pend;
  dsps_dir_t   run_dir;
  logic [15:0] saved_warning_word;

  dsps_conv_if cv ();

  dsps_warn_latch u_warn (
    .i_clk    (i_clk),
    .i_srst   (i_srst),
    .i_active (i_warn_active),
    .i_clear  (i_fault_clear_command),
    .o_saved  (saved_warning_word)
  );

  dsps_scaler u_scaler (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .cv     (cv)
  );

  // ****************************************************************
  // parameter decode
  // ****************************************************************
  wire hit_class = (i_par_addr == `DSPS_OFS_TRACK_CLASS);
  wire hit_den   = (i_par_addr == `DSPS_OFS_SCALE_DEN);
  wire hit_num   = (i_par_addr == `DSPS_OFS_SCALE_NUM);
  wire hit_act   = (i_par_addr == `DSPS_OFS_ACTION_WORD);
  wire hit_stop  = (i_par_addr == `DSPS_OFS_STOP_ERROR);
  wire hit_warn  = (i_par_addr == `DSPS_OFS_SAVED_WARN);
  wire hit_any   = hit_class | hit_den | hit_num | hit_act | hit_stop | hit_warn;

  wire class_ok  = (i_par_wdata >= {16'h0000, `DSPS_TRACK_CLASS_MIN}) &&
                   (i_par_wdata <= {16'h0000, `DSPS_TRACK_CLASS_MAX});
  wire scale_ok  = (i_par_wdata >= `DSPS_SCALE_MIN) &&
                   (i_par_wdata <= `DSPS_SCALE_MAX);
  // scaling is frozen while the power stage runs
  wire scale_lock = i_power_enabled;

  wire wr_class  = i_par_wr & hit_class & class_ok;
  wire wr_den    = i_par_wr & hit_den & scale_ok & ~scale_lock;
  wire wr_num    = i_par_wr & hit_num & scale_ok & ~scale_lock;
  // read-only words and bad values refuse the write
  wire wr_refuse = i_par_wr & ~(wr_class | wr_den | wr_num);

  wire [31:0] rd_mux =
      hit_class ? {16'h0000, tracking_error_class}   :
      hit_den   ? scale_denominator_reg              :
      hit_num   ? scale_numerator_reg                :
      hit_act   ? {16'h0000, drive_action_word}      :
      hit_stop  ? {16'h0000, last_stop_error_number} :
      hit_warn  ? {16'h0000, saved_warning_word}     : 32'h0000_0000;

  // ****************************************************************
  // action word
  // ****************************************************************
  wire [31:0] speed_mag  = dsps_abs32(i_motor_speed_rpm);
  wire        standstill = speed_mag < `DSPS_STANDSTILL_RPM;
  wire        rot_cw     = ~standstill & ~i_motor_speed_rpm[31];
  wire        rot_ccw    = ~standstill & i_motor_speed_rpm[31];

  logic [15:0] next_action;
  always_comb begin
    next_action                        = 16'h0000;
    next_action[`DSPS_ACT_WARNING]     = |i_warn_active;
    next_action[`DSPS_ACT_CLASS1 +: 4] = i_err_class_active;
    next_action[`DSPS_ACT_STANDSTILL]  = standstill;
    next_action[`DSPS_ACT_CW]          = rot_cw;
    next_action[`DSPS_ACT_CCW]         = rot_ccw;
    next_action[`DSPS_ACT_PG_IDLE]     = i_pg_idle;
    next_action[`DSPS_ACT_PG_ACCEL]    = i_pg_accel;
    next_action[`DSPS_ACT_PG_CONST]    = i_pg_const;
  end

  // ****************************************************************
  // standstill deviation filter
  // ****************************************************************
  // the detent holds the shaft; chasing sub-detent error only heats it
  wire [31:0] dev_mag    = dsps_abs32(i_pos_deviation);
  wire        dev_ignore = standstill && (dev_mag < `DSPS_DETENT_HALF);
  wire signed [31:0] next_dev = dev_ignore ? 32'sh0000_0000 : i_pos_deviation;

  // ****************************************************************
  // conversion requests
  // ****************************************************************
  wire pwr_rise  = i_power_enabled & ~pwr_q;
  wire want_int  = enable_pend | i_to_int_req;
  wire start_int = want_int & ~cv.busy;
  wire start_usr = i_to_usr_req & ~want_int & ~cv.busy;

  assign cv.req   = start_int | start_usr;
  assign cv.dir   = start_usr ? DSPS_TO_USR : DSPS_TO_INT;
  assign cv.value = start_usr ? i_int_pos : i_user_pos;
  assign cv.num   = active_num;
  assign cv.den   = active_den;

  // ****************************************************************
  // state
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tracking_error_class  <= `DSPS_TRACK_CLASS_RST;
      scale_numerator_reg   <= `DSPS_SCALE_NUM_RST;
      scale_denominator_reg <= `DSPS_SCALE_DEN_RST;
      active_num            <= `DSPS_SCALE_NUM_RST;
      active_den            <= `DSPS_SCALE_DEN_RST;
    end else begin
      if (wr_class) begin
        tracking_error_class <= i_par_wdata[15:0];
      end
      if (wr_den) begin
        scale_denominator_reg <= i_par_wdata;
      end
      if (wr_num) begin
        scale_numerator_reg <= i_par_wdata;
        active_num          <= i_par_wdata;
        active_den          <= scale_denominator_reg;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      last_stop_error_number <= 16'h0000;
      drive_action_word      <= 16'h0000;
      pwr_q                  <= 1'b0;
      enable_pend            <= 1'b0;
      run_dir                <= DSPS_TO_INT;
    end else begin
      if (i_stop_fault_valid) begin
        last_stop_error_number <= i_stop_fault_number;
      end
      drive_action_word <= next_action;
      pwr_q             <= i_power_enabled;
      // an enable edge waits until the scaler is free
      enable_pend       <= pwr_rise | (enable_pend & ~start_int);
      if (cv.req) begin
        run_dir <= cv.dir;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_par_rdata      <= 32'h0000_0000;
      o_par_ack        <= 1'b0;
      o_par_err        <= 1'b0;
      o_int_pos        <= 32'sh0000_0000;
      o_user_pos       <= 32'sh0000_0000;
      o_conv_done      <= 1'b0;
      o_range_error    <= 1'b0;
      o_ctrl_deviation <= 32'sh0000_0000;
    end else begin
      o_par_ack        <= i_par_wr | i_par_rd;
      o_par_err        <= wr_refuse | (i_par_rd & ~hit_any);
      if (i_par_rd) begin
        o_par_rdata <= rd_mux;
      end
      o_conv_done      <= cv.done;
      if (cv.done) begin
        o_range_error <= cv.ovf;
        if (run_dir == DSPS_TO_INT) begin
          o_int_pos <= cv.result;
        end else begin
          o_user_pos <= cv.result;
        end
      end
      o_ctrl_deviation <= next_dev;
    end
  end

  assign o_saved_warning_word   = saved_warning_word;
  assign o_drive_action_word    = drive_action_word;
  assign o_tracking_error_class = tracking_error_class;

endmodule : dsps_status_scale

//--- dsps_cfg.svh
// Purpose : constants for drive status and position scaling
// Assumes : included by every design file of the block that uses its macros
// Notes   : parameter offsets are the drive's own parameter addresses
`ifndef DSPS_CFG_SVH
`define DSPS_CFG_SVH

// ****************************************************************
// parameter offsets
// ****************************************************************
`define DSPS_OFS_TRACK_CLASS   16'h0516
`define DSPS_OFS_SCALE_DEN     16'h060e
`define DSPS_OFS_SCALE_NUM     16'h0610
`define DSPS_OFS_ACTION_WORD   16'h1c08
`define DSPS_OFS_STOP_ERROR    16'h1c0a
`define DSPS_OFS_SAVED_WARN    16'h1c18

// ****************************************************************
// reset values and ranges
// ****************************************************************
`define DSPS_TRACK_CLASS_RST   16'h0003
`define DSPS_TRACK_CLASS_MIN   16'h0001
`define DSPS_TRACK_CLASS_MAX   16'h0003
`define DSPS_SCALE_DEN_RST     32'h0000_000c
`define DSPS_SCALE_NUM_RST     32'h0000_0001
`define DSPS_SCALE_MIN         32'h0000_0001
`define DSPS_SCALE_MAX         32'h7fff_ffff

// ****************************************************************
// saved warning word layout
// ****************************************************************
`define DSPS_WARN_VALID_MASK   16'h7ff7
`define DSPS_WARN_AUTO_MASK    16'h2c00

// ****************************************************************
// action word bit positions
// ****************************************************************
`define DSPS_ACT_WARNING       0
`define DSPS_ACT_CLASS1        1
`define DSPS_ACT_STANDSTILL    6
`define DSPS_ACT_CW            7
`define DSPS_ACT_CCW           8
`define DSPS_ACT_PG_IDLE       11
`define DSPS_ACT_PG_ACCEL      12
`define DSPS_ACT_PG_CONST      13

// ****************************************************************
// motion and scaling figures
// ****************************************************************
`define DSPS_STANDSTILL_RPM    32'h0000_0009
`define DSPS_INT_SHIFT         17
`define DSPS_DIV_STEPS         7'h50
`define DSPS_DETENT_HALF       32'h0000_1555

`endif

//--- dsps_pkg.sv
// Purpose : shared types of drive status and position scaling
// Assumes : nothing
// Notes   : constants live in dsps_cfg.svh
package dsps_pkg;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    DSPS_IDLE = 2'b00,
    DSPS_LOAD = 2'b01,
    DSPS_DIV  = 2'b11,
    DSPS_DONE = 2'b10
  } dsps_state_t;

  typedef enum logic {
    DSPS_TO_INT = 1'b0,
    DSPS_TO_USR = 1'b1
  } dsps_dir_t;

  // magnitude of a signed word
  function automatic logic [31:0] dsps_abs32(input logic signed [31:0] v);
    dsps_abs32 = v[31] ? 32'(-v) : 32'(v);
  endfunction : dsps_abs32

endpackage : dsps_pkg

//--- dsps_conv_if.sv
// Purpose : carries one conversion request between top and scaler
// Assumes : one clock domain
// Notes   : req is a one-cycle pulse, taken only while busy is low
`timescale 1ns/1ps
interface dsps_conv_if;
  import dsps_pkg::*;
  logic                req;
  dsps_dir_t           dir;
  logic signed [31:0]  value;
  logic        [31:0]  num;
  logic        [31:0]  den;
  logic                busy;
  logic                done;
  logic                ovf;
  logic signed [31:0]  result;

  modport master (output req, dir, value, num, den, input busy, done, ovf, result);
  modport conv   (input req, dir, value, num, den, output busy, done, ovf, result);
endinterface : dsps_conv_if

//--- dsps_scaler.sv
// Purpose : converts positions between user units and internal units
// Assumes : num and den nonzero and held steady while busy
// Notes   : internal units are 1/131072 of a motor revolution
`timescale 1ns/1ps
`include "dsps_cfg.svh"
module dsps_scaler
  import dsps_pkg::*;
(
  // clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_srst,
  // conversion port
  dsps_conv_if.conv  cv
);

  dsps_state_t        state;
  logic [79:0]        dq;
  logic [47:0]        rem;
  logic [47:0]        dvs;
  logic [6:0]         cnt;
  logic               neg;
  logic               done;
  logic               ovf;
  logic signed [31:0] result;
  dsps_dir_t          dir_q;
  logic [31:0]        mag_q;

  // ****************************************************************
  // operand setup
  // ****************************************************************
  // value and direction are captured at the request; the port moves on after it
  wire [31:0] mag     = dsps_abs32(cv.value);
  wire [31:0] mult    = (dir_q == DSPS_TO_INT) ? cv.num : cv.den;
  wire [63:0] prod    = {32'h0000_0000, mag_q} * {32'h0000_0000, mult};
  wire [79:0] to_int  = {prod, 16'h0000} << 1;
  wire [79:0] to_usr  = {16'h0000, prod};
  wire [47:0] den_int = {16'h0000, cv.den};
  wire [47:0] num_usr = {cv.num[30:0], 17'h0_0000};
  wire [79:0] next_dq_load  = (dir_q == DSPS_TO_INT) ? to_int : to_usr;
  wire [47:0] next_dvs_load = (dir_q == DSPS_TO_INT) ? den_int : num_usr;

  // ****************************************************************
  // restoring divide step, truncates toward zero on the magnitude
  // ****************************************************************
  wire [48:0] trial   = {rem, dq[79]};
  wire        fits    = trial >= {1'b0, dvs};
  wire [48:0] diff    = trial - {1'b0, dvs};
  wire [47:0] next_rem = fits ? diff[47:0] : trial[47:0];
  wire        too_big = |dq[79:31];
  wire [31:0] q_lo    = dq[31:0];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state  <= DSPS_IDLE;
      dq     <= '0;
      rem    <= '0;
      dvs    <= '0;
      cnt    <= '0;
      neg    <= 1'b0;
      done   <= 1'b0;
      ovf    <= 1'b0;
      result <= '0;
      dir_q  <= DSPS_TO_INT;
      mag_q  <= '0;
    end else begin
      done <= 1'b0;
      case (state)
        DSPS_IDLE: begin
          if (cv.req) begin
            neg   <= cv.value[31];
            mag_q <= mag;
            dir_q <= cv.dir;
            state <= DSPS_LOAD;
          end
        end
        DSPS_LOAD: begin
          dq    <= next_dq_load;
          dvs   <= next_dvs_load;
          rem   <= '0;
          cnt   <= `DSPS_DIV_STEPS;
          state <= DSPS_DIV;
        end
        DSPS_DIV: begin
          dq  <= {dq[78:0], fits};
          rem <= next_rem;
          cnt <= cnt - 7'h01;
          if (cnt == 7'h01) begin
            state <= DSPS_DONE;
          end
        end
        DSPS_DONE: begin
          done   <= 1'b1;
          ovf    <= too_big;
          result <= too_big ? 32'sh0000_0000 :
                    (neg ? $signed(32'(-q_lo)) : $signed(q_lo));
          state  <= DSPS_IDLE;
        end
        default: begin
          state <= DSPS_IDLE;
        end
      endcase
    end
  end

  assign cv.busy   = (state != DSPS_IDLE);
  assign cv.done   = done;
  assign cv.ovf    = ovf;
  assign cv.result = result;

endmodule : dsps_scaler

//--- dsps_warn_latch.sv
// Purpose : saved warning word
// Assumes : warning sources are levels, one bit per source
// Notes   : a new warning in the clear cycle survives the clear
`timescale 1ns/1ps
`include "dsps_cfg.svh"
module dsps_warn_latch (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // sources and clear
  input  wire logic [15:0] i_active,
  input  wire logic        i_clear,
  // saved word
  output logic      [15:0] o_saved
);

  wire [15:0] kept        = i_clear ? 16'h0000 : (o_saved & ~`DSPS_WARN_AUTO_MASK);
  wire [15:0] next_saved  = (i_active | kept) & `DSPS_WARN_VALID_MASK;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_saved <= 16'h0000;
    end else begin
      o_saved <= next_saved;
    end
  end

endmodule : dsps_warn_latch

//--- dsps_asserts.sv
// Purpose : port-level checks of dsps_status_scale
// Assumes : one clock, synchronous reset
// Notes   : scaler busy is tracked here from requests and done
`timescale 1ns/1ps
`include "dsps_cfg.svh"
module dsps_asserts (
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_srst,
  // inputs watched
  input  wire logic               i_par_wr,
  input  wire logic        [15:0] i_par_addr,
  input  wire logic        [15:0] i_warn_active,
  input  wire logic               i_fault_clear_command,
  input  wire logic        [3:0]  i_err_class_active,
  input  wire logic signed [31:0] i_motor_speed_rpm,
  input  wire logic               i_pg_idle,
  input  wire logic               i_pg_accel,
  input  wire logic               i_pg_const,
  input  wire logic               i_power_enabled,
  input  wire logic               i_to_int_req,
  input  wire logic               i_to_usr_req,
  // outputs watched
  input  wire logic               o_par_err,
  input  wire logic        [15:0] o_saved_warning_word,
  input  wire logic        [15:0] o_drive_action_word,
  input  wire logic               o_conv_done
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // ****************************************************************
  // helper logic
  // ****************************************************************
  logic busy_q;
  wire  scale_wr = i_par_wr && (i_par_addr == `DSPS_OFS_SCALE_NUM ||
                                i_par_addr == `DSPS_OFS_SCALE_DEN);

  // power-enable conversions are not tracked, the bench never overlaps them
  always_ff @(posedge i_clk) begin
    if (i_srst || o_conv_done) busy_q <= 1'b0;
    else if (i_to_int_req || i_to_usr_req) busy_q <= 1'b1;
  end

  sequence s_taken;
    (i_to_int_req || i_to_usr_req) && !busy_q;
  endsequence
  sequence s_answer;
    ##[83:85] o_conv_done ##1 !o_conv_done;
  endsequence

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_clear_empties: assert property (i_fault_clear_command && i_warn_active == 16'h0000
    |=> o_saved_warning_word == 16'h0000) else $error("saved warnings not cleared");
  a_auto_bits_follow: assert property (1'b1 |=> o_saved_warning_word[13] ==
    $past(i_warn_active[13]) && o_saved_warning_word[11:10] == $past(i_warn_active[11:10]))
    else $error("auto bits do not follow source");
  a_reserved_zero: assert property ((o_saved_warning_word & 16'h8008) == 16'h0000)
    else $error("reserved warning bit set");
  a_class_bits: assert property (1'b1 |=> o_drive_action_word[4:1] ==
    $past(i_err_class_active)) else $error("error class bits wrong");
  a_standstill_bit: assert property (i_motor_speed_rpm > -32'sd9 &&
    i_motor_speed_rpm < 32'sd9 |=> o_drive_action_word[6]) else $error("standstill missing");
  a_turn_cw: assert property (i_motor_speed_rpm >= 32'sd9 |=>
    o_drive_action_word[8:7] == 2'b01) else $error("direction bits wrong");
  a_pg_bits: assert property (1'b1 |=> o_drive_action_word[13:11] ==
    $past({i_pg_const, i_pg_accel, i_pg_idle})) else $error("generator bits wrong");
  a_scale_refused: assert property (scale_wr && i_power_enabled |=> o_par_err)
    else $error("scaling write accepted while enabled");
  a_conv_answer: assert property (s_taken |-> s_answer)
    else $error("conversion answer late or long");
endmodule : dsps_asserts

bind dsps_status_scale dsps_asserts i_chk (.*);

//--- dsps_fb_master.sv
// Purpose : fieldbus master model on the parameter port
// Assumes : one-cycle strobes, ack one cycle after the taken edge
// Notes   : write data is inverted once released
`timescale 1ns/1ps
module dsps_fb_master (
  // clock
  input  wire logic        i_clk,
  // parameter port
  output logic             o_wr,
  output logic             o_rd,
  output logic      [15:0] o_addr,
  output logic      [31:0] o_wdata,
  input  wire logic [31:0] i_rdata,
  input  wire logic        i_ack,
  input  wire logic        i_err
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 16'h0000;
    o_wdata = 32'h0000_0000;
  end

  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic ok);
    int n;
    @(negedge i_clk);
    o_wr = w;
    o_rd = !w;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = ~d;
    ok = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      if (i_ack === 1'b1) ok = 1'b1;
      else @(negedge i_clk);
    end
    q = i_rdata;
    e = i_err;
  endtask : xfer
endmodule : dsps_fb_master

//--- tb_top.sv
// Purpose : self-checking bench of dsps_status_scale
// Assumes : inputs change at the falling edge
// Notes   : expectations follow the documented factor num/den
`timescale 1ns/1ps
`include "dsps_cfg.svh"
module tb_top;
  logic clk, srst, wr, rd, ack, err, fclr, sfv, idle, accel, cnst, pwr, ireq, ureq;
  logic done, rerr;
  logic [15:0] addr, warn, sfn, saved, act, tcls;
  logic [31:0] wdata, rdata;
  logic [3:0] ecls;
  logic signed [31:0] spd, upos, ipos, dev, opi, opu, cdev;
  int fails, n_tests;

  dsps_fb_master i_mst (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata), .i_rdata(rdata), .i_ack(ack), .i_err(err));
  dsps_status_scale i_dut (.i_clk(clk), .i_srst(srst), .i_par_wr(wr), .i_par_rd(rd),
    .i_par_addr(addr), .i_par_wdata(wdata), .o_par_rdata(rdata), .o_par_ack(ack),
    .o_par_err(err), .i_warn_active(warn), .i_fault_clear_command(fclr),
    .i_err_class_active(ecls), .i_stop_fault_valid(sfv), .i_stop_fault_number(sfn),
    .i_motor_speed_rpm(spd), .i_pg_idle(idle), .i_pg_accel(accel), .i_pg_const(cnst),
    .i_power_enabled(pwr), .i_user_pos(upos), .i_to_int_req(ireq), .i_int_pos(ipos),
    .i_to_usr_req(ureq), .i_pos_deviation(dev), .o_saved_warning_word(saved),
    .o_drive_action_word(act), .o_tracking_error_class(tcls), .o_int_pos(opi),
    .o_user_pos(opu), .o_conv_done(done), .o_range_error(rerr), .o_ctrl_deviation(cdev));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // a read compares d as expected data, a write compares only the error
  task automatic acc(input string nm, input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic e, ok;
    i_mst.xfer(w, a, d, q, e, ok);
    if (ok !== 1'b1) begin
      fails++;
      give_verdict();
    end
    chk({nm, " err"}, {31'h0, ee}, {31'h0, e});
    if (!w) chk(nm, d, q);
  endtask : acc

  task automatic wait_done(input string nm, input logic to_usr, input logic [31:0] exp,
                           input logic ee);
    int n;
    for (n = 0; n < 200 && done !== 1'b1; n++) @(negedge clk);
    if (n == 200) begin
      fails++;
      give_verdict();
    end
    chk(nm, exp, to_usr ? opu : opi);
    chk({nm, " range"}, {31'h0, ee}, {31'h0, rerr});
    @(negedge clk);
  endtask : wait_done

  task automatic conv(input string nm, input logic to_usr, input logic [31:0] v,
                      input logic [31:0] exp, input logic ee);
    @(negedge clk);
    upos = v;
    ipos = v;
    ureq = to_usr;
    ireq = !to_usr;
    @(negedge clk);
    ureq = 1'b0;
    ireq = 1'b0;
    wait_done(nm, to_usr, exp, ee);
  endtask : conv

  task automatic status(input logic [3:0] c, input logic [31:0] s, input logic [2:0] pg,
                        input logic [15:0] exp);
    ecls = c;
    spd = s;
    {cnst, accel, idle} = pg;
    @(negedge clk);
    chk("action word", {16'h0, exp}, {16'h0, act});
  endtask : status

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    acc("class", 0, `DSPS_OFS_TRACK_CLASS, 32'h0000_0003, 0);
    acc("den", 0, `DSPS_OFS_SCALE_DEN, 32'h0000_000c, 0);
    acc("num", 0, `DSPS_OFS_SCALE_NUM, 32'h0000_0001, 0);
    acc("stop", 0, `DSPS_OFS_STOP_ERROR, 32'h0000_0000, 0);
    acc("saved", 0, `DSPS_OFS_SAVED_WARN, 32'h0000_0000, 0);
    acc("unmapped", 0, 16'h0000, 32'h0000_0000, 1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_warn();
    warn = 16'hffff;
    @(negedge clk);
    chk("saved all", 32'h0000_7ff7, {16'h0, saved});
    chk("warning bit", 32'h0000_0001, {31'h0, act[0]});
    warn = 16'h0000;
    @(negedge clk);
    chk("saved auto", 32'h0000_53f7, {16'h0, saved});
    fclr = 1'b1;
    @(negedge clk);
    fclr = 1'b0;
    chk("saved clear", 32'h0000_0000, {16'h0, saved});
    $display("test warnings done");
  endtask : t_warn

  task automatic t_action();
    status(4'b1010, 32'hffff_ffec, 3'b010, 16'h1114);
    status(4'b0000, 32'h0000_0005, 3'b001, 16'h0840);
    status(4'b0101, 32'h0000_0009, 3'b100, 16'h208a);
    acc("action reg", 0, `DSPS_OFS_ACTION_WORD, 32'h0000_208a, 0);
    spd = 32'h0000_0000;
    dev = 32'h0000_0064;
    repeat (2) @(negedge clk);
    chk("dev small", 32'h0000_0000, cdev);
    dev = 32'h0000_1770;
    @(negedge clk);
    chk("dev large", 32'h0000_1770, cdev);
    $display("test action done");
  endtask : t_action

  task automatic t_regs();
    sfn = 16'h00a5;
    sfv = 1'b1;
    @(negedge clk);
    sfv = 1'b0;
    acc("stop num", 0, `DSPS_OFS_STOP_ERROR, 32'h0000_00a5, 0);
    acc("stop wr", 1, `DSPS_OFS_STOP_ERROR, 32'h0000_0001, 1);
    acc("class wr", 1, `DSPS_OFS_TRACK_CLASS, 32'h0000_0002, 0);
    acc("class 0", 1, `DSPS_OFS_TRACK_CLASS, 32'h0000_0000, 1);
    acc("class 4", 1, `DSPS_OFS_TRACK_CLASS, 32'h0000_0004, 1);
    acc("class rd", 0, `DSPS_OFS_TRACK_CLASS, 32'h0000_0002, 0);
    acc("class 1", 1, `DSPS_OFS_TRACK_CLASS, 32'h0000_0001, 0);
    chk("class out", 32'h0000_0001, {16'h0, tcls});
    $display("test registers done");
  endtask : t_regs

  task automatic t_scale();
    acc("den wr", 1, `DSPS_OFS_SCALE_DEN, 32'h0000_0003, 0);
    conv("den only", 0, 32'h0000_0006, 32'h0001_0000, 0);
    acc("num wr", 1, `DSPS_OFS_SCALE_NUM, 32'h0000_0002, 0);
    conv("to int", 0, 32'h0000_0006, 32'h0008_0000, 0);
    conv("negative", 0, 32'hffff_ffff, 32'hfffe_aaab, 0);
    conv("to usr", 1, 32'h0008_0000, 32'h0000_0006, 0);
    conv("overflow", 0, 32'h7fff_ffff, 32'h0000_0000, 1);
    acc("num 0", 1, `DSPS_OFS_SCALE_NUM, 32'h0000_0000, 1);
    acc("den big", 1, `DSPS_OFS_SCALE_DEN, 32'h8000_0000, 1);
    upos = 32'h0000_0003;
    pwr = 1'b1;
    wait_done("power on", 0, 32'h0004_0000, 0);
    acc("num on", 1, `DSPS_OFS_SCALE_NUM, 32'h0000_0005, 1);
    acc("num kept", 0, `DSPS_OFS_SCALE_NUM, 32'h0000_0002, 0);
    pwr = 1'b0;
    $display("test scaling done");
  endtask : t_scale

  initial begin
    {srst, fclr, sfv, idle, accel, cnst, pwr, ireq, ureq} = 9'h1_00;
    {warn, sfn, ecls} = 36'h0_0000_0000;
    {spd, upos, ipos, dev} = 128'h0;
    fails = 0;
    n_tests = 0;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_warn();
    t_action();
    t_regs();
    t_scale();
    give_verdict();
  end
endmodule : tb_top
